// File: design/gtp_pkg.sv
/*
 * Shared constants and types for the general timer block with a cascadable pair.
 * Assumes a 32-bit APB master and a 100 MHz core clock that stands for the oscillator.
 */
package gtp_pkg;

   localparam int NTMR = 3;

   // apb byte offsets
   localparam logic [7:0] OFS_STANDALONE_CTL = 8'h00;
   localparam logic [7:0] OFS_PAIR_LOW_CTL   = 8'h04;
   localparam logic [7:0] OFS_PAIR_HIGH_CTL  = 8'h08;
   localparam logic [7:0] OFS_STANDALONE_PER = 8'h0c;
   localparam logic [7:0] OFS_PAIR_LOW_PER   = 8'h10;
   localparam logic [7:0] OFS_PAIR_HIGH_PER  = 8'h14;
   localparam logic [7:0] OFS_STANDALONE_CNT = 8'h18;
   localparam logic [7:0] OFS_PAIR_LOW_CNT   = 8'h1c;
   localparam logic [7:0] OFS_PAIR_HIGH_CNT  = 8'h20;
   localparam logic [7:0] OFS_IRQ_STATUS     = 8'h24;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'h28;

   // control field positions
   localparam int RUN_BIT       = 15;
   localparam int HALT_IDLE_BIT = 13;
   localparam int GATE_BIT      = 6;
   localparam int PS_HI_BIT     = 5;
   localparam int PS_LO_BIT     = 4;
   localparam int CASCADE_BIT   = 3;
   localparam int SYNC_BIT      = 2;
   localparam int CLKSRC_BIT    = 1;

   // implemented control bits per timer
   localparam logic [15:0] CTL_MASK_STANDALONE = 16'ha076;
   localparam logic [15:0] CTL_MASK_PAIR_LOW   = 16'ha07a;
   localparam logic [15:0] CTL_MASK_PAIR_HIGH  = 16'ha072;

   localparam logic [15:0] CTL_RESET   = 16'h0000;
   localparam logic [15:0] PER_RESET   = 16'hffff;
   localparam logic [15:0] CNT_RESET   = 16'h0000;
   localparam logic [2:0]  IRQ_RESET   = 3'h0;

   // prescaler terminal counts (ratio minus one)
   localparam logic [7:0] PS_LAST_1   = 8'h00;
   localparam logic [7:0] PS_LAST_8   = 8'h07;
   localparam logic [7:0] PS_LAST_64  = 8'h3f;
   localparam logic [7:0] PS_LAST_256 = 8'hff;

   // instruction clock is the core clock divided by this
   localparam int INSTR_DIV = 2;

   // interrupt status bit positions
   localparam int IRQ_STANDALONE = 0;
   localparam int IRQ_PAIR_LOW   = 1;
   localparam int IRQ_PAIR_HIGH  = 2;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } gtp_apb_req_type;

endpackage

// File: design/gtp_timer.sv
/*
 * Standalone 16-bit timer plus a pair of 16-bit timers that cascade into one 32-bit
 * timer, with prescaler, gated accumulation, interrupt status/mask and A/D trigger.
 * Assumes APB master on core_clk; timer pins and idle level are synchronous-clean inputs.
 */
// The APB register port and the register offsets are this design's own decisions.
// Notes on behaviour
// R01: run bit (bit 15) starts the timer; clearing it stops the timer.
// R02: halt-in-idle bit set stops the timer while the chip idles.
// R03: gate bit counts internal clock only while gate is high; ignored on external clock.
// R04: prescale field 11=1:256, 10=1:64, 01=1:8, 00=1:1.
// R05: standalone external clock is synchronised when sync bit set; ignored on internal clock.
// R06: clock-source bit set counts external rising edges, clear counts instruction clock.
// R07: control write while running resets the prescale counter.
// R08: standalone flag on period match or gate falling edge during gated accumulation.
// R09: standalone runs as timer, synchronous counter or asynchronous counter.
// R10: pair timers never count asynchronously; their inputs are always synchronised.
// R11: cascade bit in pair low control joins the pair; high control ignored.
// R12: in 32-bit mode the match flag appears on the pair high flag.
// R13: in 32-bit mode high count holds upper word, low count lower word.
// R14: in 32-bit mode compare against high period : low period.
// R15: A/D trigger comes from the 32-bit pair or the pair high timer.
// R16: software sets up everything first and sets the run bit last.
// R17: each prescaled tick increments; on period match count clears and flag sets.
// R18: unimplemented control bits read zero; control clears at reset.
`timescale 1ns/1ps
module gtp_timer
   import gtp_pkg::*;
(
   input  wire logic                     core_clk,    // oscillator-rate clock
   input  wire logic                     rst_b,       // async reset, active low
   input  wire gtp_pkg::gtp_apb_req_type apbReq,      // apb request bundle
   output logic [31:0]                   prdata,      // apb read data
   output logic                          pready,      // apb ready
   output logic                          pslverr,     // apb error, unmapped address
   input  wire logic [2:0]               timerPin,    // clock/gate pins: standalone, low, high
   input  wire logic                     chipIdle,    // chip is in idle
   output logic                          irq,         // level interrupt
   output logic                          adcTrigger   // one-cycle a/d start pulse
);

   logic [15:0] ctlReg [NTMR];
   logic [15:0] perReg [NTMR];
   logic [15:0] cntReg [NTMR];
   logic [7:0]  preReg [NTMR];
   logic [2:0]  pinS1Reg;
   logic [2:0]  pinS2Reg;
   logic [2:0]  pinPrevReg;
   logic [2:0]  statusReg;
   logic [2:0]  maskReg;
   logic [2:0]  statusNext;
   logic        instrPhaseReg;
   logic        preadyReg;
   logic        pslverrReg;
   logic [31:0] prdataReg;
   logic        irqReg;
   logic        adcReg;

   logic [2:0]  pinLevel;
   logic [2:0]  inTick;
   logic [2:0]  preTick;
   logic [2:0]  gateEvt;
   logic [2:0]  match16;
   logic [2:0]  events;
   logic        match32;
   logic        cascade;
   logic        setupPh;
   logic        doWrite;
   logic [31:0] readValue;
   logic        unmapped;
   logic [7:0]  wAddr;

   function automatic logic [7:0] psLast(input logic [1:0] sel);
      // R04 prescale ratio
      unique case (sel)
         2'b00: psLast = PS_LAST_1;
         2'b01: psLast = PS_LAST_8;
         2'b10: psLast = PS_LAST_64;
         2'b11: psLast = PS_LAST_256;
      endcase
   endfunction

   function automatic logic [15:0] ctlMask(input int idx);
      // R18 unimplemented bits
      if (idx == 0) begin
         ctlMask = CTL_MASK_STANDALONE;
      end else if (idx == 1) begin
         ctlMask = CTL_MASK_PAIR_LOW;
      end else begin
         ctlMask = CTL_MASK_PAIR_HIGH;
      end
   endfunction

   // one decode for every per-timer register address
   function automatic logic regHit(input logic [7:0] addr, input logic [7:0] base, input int idx);
      regHit = addr == base + 8'(4 * idx);
   endfunction

   assign prdata     = prdataReg;
   assign pready     = preadyReg;
   assign pslverr    = pslverrReg;
   assign irq        = irqReg;
   assign adcTrigger = adcReg;

   assign setupPh = apbReq.psel & ~apbReq.penable;
   assign doWrite = apbReq.psel & apbReq.penable & apbReq.pwrite & preadyReg;
   assign wAddr   = apbReq.paddr;
   // R11 pair joined by low control
   assign cascade = ctlReg[1][CASCADE_BIT];

   // instruction clock at half the core rate
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         instrPhaseReg <= 1'b0;
      end else begin
         instrPhaseReg <= ~instrPhaseReg;
      end
   end

   // pin synchronisers and edge history
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pinS1Reg   <= 3'h0;
         pinS2Reg   <= 3'h0;
         pinPrevReg <= 3'h0;
      end else begin
         pinS1Reg   <= timerPin;
         pinS2Reg   <= pinS1Reg;
         pinPrevReg <= pinLevel;
      end
   end

   // per-timer tick generation
   always_comb begin
      logic [15:0] c;
      logic        active;
      logic        gated;
      logic        srcTick;
      c       = 16'h0000;
      active  = 1'b0;
      gated   = 1'b0;
      srcTick = 1'b0;
      for (int i = 0; i < NTMR; i++) begin
         c = ctlReg[i];
         // R05 R09 R10 only the standalone may bypass the synchroniser
         if (i == 0 && c[CLKSRC_BIT] && !c[SYNC_BIT]) begin
            pinLevel[i] = timerPin[i];
         end else begin
            pinLevel[i] = pinS2Reg[i];
         end
         // R01 R02 run and idle halt
         active = c[RUN_BIT] & ~(chipIdle & c[HALT_IDLE_BIT]);
         // R03 gate only with internal clock
         gated = ~c[CLKSRC_BIT] & c[GATE_BIT];
         // R06 clock source
         if (c[CLKSRC_BIT]) begin
            srcTick = pinLevel[i] & ~pinPrevReg[i];
         end else begin
            srcTick = instrPhaseReg & (~gated | pinLevel[i]);
         end
         inTick[i]  = active & srcTick;
         preTick[i] = inTick[i] & (preReg[i] == psLast(c[PS_HI_BIT:PS_LO_BIT]));
         gateEvt[i] = active & gated & ~pinLevel[i] & pinPrevReg[i];
         match16[i] = cntReg[i] == perReg[i];
      end
      // R11 high timer's own controls ignored when joined
      if (cascade) begin
         inTick[2]  = 1'b0;
         preTick[2] = 1'b0;
         gateEvt[2] = 1'b0;
      end
   end

   // R14 32-bit period compare
   assign match32 = {cntReg[2], cntReg[1]} == {perReg[2], perReg[1]};

   // interrupt events
   always_comb begin
      // R08 standalone match or gate fall
      events[IRQ_STANDALONE] = (preTick[0] & match16[0]) | gateEvt[0];
      // R12 joined pair reports on the high flag
      if (cascade) begin
         events[IRQ_PAIR_LOW]  = 1'b0;
         events[IRQ_PAIR_HIGH] = (preTick[1] & match32) | gateEvt[1];
      end else begin
         events[IRQ_PAIR_LOW]  = (preTick[1] & match16[1]) | gateEvt[1];
         events[IRQ_PAIR_HIGH] = (preTick[2] & match16[2]) | gateEvt[2];
      end
   end

   // prescale counters
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NTMR; i++) begin
            preReg[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < NTMR; i++) begin
            // R07 control write while running clears prescaler
            if (doWrite && regHit(wAddr, OFS_STANDALONE_CTL, i) && ctlReg[i][RUN_BIT]) begin
               preReg[i] <= 8'h00;
            end else if (preTick[i]) begin
               preReg[i] <= 8'h00;
            end else if (inTick[i]) begin
               preReg[i] <= preReg[i] + 8'h01;
            end
         end
      end
   end

   // control and period registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NTMR; i++) begin
            // R18 control clears at reset
            ctlReg[i] <= CTL_RESET;
            perReg[i] <= PER_RESET;
         end
      end else if (doWrite) begin
         for (int i = 0; i < NTMR; i++) begin
            if (regHit(wAddr, OFS_STANDALONE_CTL, i)) begin
               // R18 unimplemented bits held at zero
               ctlReg[i] <= apbReq.pwdata[15:0] & ctlMask(i);
            end
            if (regHit(wAddr, OFS_STANDALONE_PER, i)) begin
               perReg[i] <= apbReq.pwdata[15:0];
            end
         end
      end
   end

   // count registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NTMR; i++) begin
            cntReg[i] <= CNT_RESET;
         end
      end else begin
         for (int i = 0; i < NTMR; i++) begin
            // software load has priority over a same-cycle tick
            if (doWrite && regHit(wAddr, OFS_STANDALONE_CNT, i)) begin
               cntReg[i] <= apbReq.pwdata[15:0];
            end else if (cascade && i != 0) begin
               // R13 R17 joined count, low word carries into high
               if (preTick[1]) begin
                  if (match32) begin
                     cntReg[i] <= CNT_RESET;
                  end else if (i == 1) begin
                     cntReg[i] <= cntReg[i] + 16'h0001;
                  end else if (cntReg[1] == 16'hffff) begin
                     cntReg[i] <= cntReg[i] + 16'h0001;
                  end
               end
            end else if (preTick[i]) begin
               // R17 increment and clear on match
               if (match16[i]) begin
                  cntReg[i] <= CNT_RESET;
               end else begin
                  cntReg[i] <= cntReg[i] + 16'h0001;
               end
            end
         end
      end
   end

   // sticky status: a same-cycle event beats the write-one clear
   always_comb begin
      statusNext = statusReg;
      if (doWrite && wAddr == OFS_IRQ_STATUS) begin
         statusNext = statusReg & ~apbReq.pwdata[2:0];
      end
      statusNext = statusNext | events;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         statusReg <= IRQ_RESET;
         maskReg   <= IRQ_RESET;
         irqReg    <= 1'b0;
      end else begin
         statusReg <= statusNext;
         if (doWrite && wAddr == OFS_IRQ_MASK) begin
            maskReg <= apbReq.pwdata[2:0];
         end
         irqReg <= |(statusNext & (doWrite && wAddr == OFS_IRQ_MASK ? apbReq.pwdata[2:0] : maskReg));
      end
   end

   // R15 a/d trigger on the 32-bit pair match when joined, else on the pair high timer's period match
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         adcReg <= 1'b0;
      end else if (cascade) begin
         adcReg <= preTick[1] & match32;
      end else begin
         adcReg <= preTick[2] & match16[2];
      end
   end

   // read mux
   always_comb begin
      readValue = 32'h0000_0000;
      unmapped  = 1'b0;
      unique case (wAddr)
         OFS_STANDALONE_CTL: readValue = {16'h0000, ctlReg[0]};
         OFS_PAIR_LOW_CTL:   readValue = {16'h0000, ctlReg[1]};
         OFS_PAIR_HIGH_CTL:  readValue = {16'h0000, ctlReg[2]};
         OFS_STANDALONE_PER: readValue = {16'h0000, perReg[0]};
         OFS_PAIR_LOW_PER:   readValue = {16'h0000, perReg[1]};
         OFS_PAIR_HIGH_PER:  readValue = {16'h0000, perReg[2]};
         OFS_STANDALONE_CNT: readValue = {16'h0000, cntReg[0]};
         OFS_PAIR_LOW_CNT:   readValue = {16'h0000, cntReg[1]};
         OFS_PAIR_HIGH_CNT:  readValue = {16'h0000, cntReg[2]};
         OFS_IRQ_STATUS:     readValue = {29'h0, statusReg};
         OFS_IRQ_MASK:       readValue = {29'h0, maskReg};
         default:            unmapped  = 1'b1;
      endcase
   end

   // apb slave: read data captured in setup, write done in the access cycle, one access cycle, no waits
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         preadyReg  <= 1'b0;
         pslverrReg <= 1'b0;
         prdataReg  <= 32'h0000_0000;
      end else begin
         preadyReg  <= setupPh;
         pslverrReg <= setupPh & unmapped;
         if (setupPh && !apbReq.pwrite) begin
            prdataReg <= readValue;
         end else if (!setupPh) begin
            prdataReg <= 32'h0000_0000;
         end
      end
   end

endmodule

// File: testbench/gtp_timer_monitor.sv
/* Concurrent checks on the timer block's APB, interrupt and trigger ports.
   Assumes it is bound to gtp_timer and sees only that module's ports. */
`timescale 1ns/1ps
module gtp_timer_monitor
   import gtp_pkg::*;
(
   input wire logic                     core_clk,   // core clock
   input wire logic                     rst_b,      // reset, active low
   input wire gtp_pkg::gtp_apb_req_type apbReq,     // apb request
   input wire logic [31:0]              prdata,     // read data
   input wire logic                     pready,     // ready
   input wire logic                     pslverr,    // error
   input wire logic [2:0]               timerPin,   // timer pins
   input wire logic                     chipIdle,   // idle level
   input wire logic                     irq,        // interrupt
   input wire logic                     adcTrigger  // a/d trigger
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire logic rdDone = pready && !apbReq.pwrite;

   AST_READY_NEXT: assert property (apbReq.psel && !apbReq.penable |=> pready && apbReq.penable)
      else $error("ready missing after setup");
   AST_READY_SINGLE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   AST_CTL_UNUSED: assert property (rdDone && apbReq.paddr == OFS_STANDALONE_CTL |->
      (prdata & ~{16'h0, CTL_MASK_STANDALONE}) == 32'h0)
      else $error("unimplemented control bit reads one");
   AST_ERR_UNMAPPED: assert property (pready && apbReq.paddr > OFS_IRQ_MASK |-> pslverr)
      else $error("no error on unmapped address");
   AST_ERR_MAPPED: assert property (pready && apbReq.paddr <= OFS_IRQ_MASK && apbReq.paddr[1:0] == 2'h0
      |-> !pslverr)
      else $error("error on mapped address");
   AST_STATUS_WIDTH: assert property (rdDone && apbReq.paddr == OFS_IRQ_STATUS |-> prdata[31:3] == 29'h0)
      else $error("status upper bits set");
   AST_ADC_PULSE: assert property (adcTrigger |=> !adcTrigger)
      else $error("trigger longer than one cycle");
   AST_IRQ_CLEAR: assert property ($fell(irq) |-> $past(pready && apbReq.pwrite, 1))
      else $error("interrupt dropped without a write");
endmodule

bind gtp_timer gtp_timer_monitor u_mon (.core_clk(core_clk), .rst_b(rst_b), .apbReq(apbReq),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerPin(timerPin), .chipIdle(chipIdle),
   .irq(irq), .adcTrigger(adcTrigger));

// File: testbench/gtp_pin_model.sv
/* Model of the external clock/gate pins feeding the three timers.
   Assumes the bench calls its tasks from the core clock domain. */
`timescale 1ns/1ps
module gtp_pin_model (
   input  wire logic  core_clk,  // pin timing reference
   output logic [2:0] timerPin   // clock/gate pins
);
   initial timerPin = 3'h0;
   // rising edges; at least four cycles each level so the two-flop sync sees every one
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge core_clk);
         timerPin[idx] <= 1'b1;
         repeat (4) @(posedge core_clk);
         timerPin[idx] <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask
   task automatic level(input int idx, input logic v);
      @(posedge core_clk);
      timerPin[idx] <= v;
   endtask
endmodule

// File: testbench/gtp_timer_test.sv
/* Self-checking bench for the timer block, driven through APB and the pin model.
   Assumes the package offsets and a 100 MHz core clock. */
`timescale 1ns/1ps
module gtp_timer_test;
   import gtp_pkg::*;
   logic            core_clk, rst_b, chipIdle, irq, adcTrigger, pready, pslverr, err;
   logic [31:0]     prdata, rd;
   logic [2:0]      timerPin;
   gtp_apb_req_type apbReq;
   int              n_fail, compares, cyc, adcSeen, a0;
   logic [7:0]      ctlAdr[3] = '{OFS_STANDALONE_CTL, OFS_PAIR_LOW_CTL, OFS_PAIR_HIGH_CTL};
   logic [15:0]     ctlMsk[3] = '{CTL_MASK_STANDALONE, CTL_MASK_PAIR_LOW, CTL_MASK_PAIR_HIGH};
   logic [7:0]      exCtl[3]  = '{OFS_STANDALONE_CTL, OFS_STANDALONE_CTL, OFS_PAIR_LOW_CTL};
   logic [7:0]      exCnt[3]  = '{OFS_STANDALONE_CNT, OFS_STANDALONE_CNT, OFS_PAIR_LOW_CNT};
   logic [31:0]     exVal[3]  = '{32'h8002, 32'h8006, 32'h8002};
   int              ratio[4]  = '{1, 8, 64, 256};

   gtp_timer u_dut (.core_clk(core_clk), .rst_b(rst_b), .apbReq(apbReq), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timerPin(timerPin), .chipIdle(chipIdle), .irq(irq), .adcTrigger(adcTrigger));
   gtp_pin_model u_pin (.core_clk(core_clk), .timerPin(timerPin));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (adcTrigger === 1'b1) adcSeen <= adcSeen + 1;
      if (cyc == 30000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // held until pready is sampled high, then released
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apbReq <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   task automatic rng(input logic [31:0] v, input int e, input int t);
      check({31'h0, (v >= e - t) && (v <= e + t)}, 32'h1);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic waitirq;
      for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge core_clk);
   endtask

   initial begin
      apbReq = '0;
      chipIdle = 1'b0;
      rst_b = 1'b0;
      n_fail = 0;
      compares = 0;
      cyc = 0;
      adcSeen = 0;
      waitc(10);
      rst_b <= 1'b1;
      rdc(OFS_STANDALONE_PER, 32'hffff);
      rdc(OFS_IRQ_STATUS, 32'h0);
      for (int i = 0; i < 3; i++) begin
         rdc(ctlAdr[i], 32'h0);
         wr(ctlAdr[i], 32'h7fff);
         rdc(ctlAdr[i], {16'h0, ctlMsk[i]} & 32'h7fff);
         wr(ctlAdr[i], 32'h0);
      end
      apb(1'b0, 8'h40, 32'h0);
      check({31'h0, err}, 32'h1);
      for (int p = 0; p < 4; p++) begin
         wr(OFS_STANDALONE_CNT, 32'h0);
         wr(OFS_STANDALONE_CTL, 32'h8000 | (p << 4));
         waitc(2048);
         wr(OFS_STANDALONE_CTL, 32'h0);
         apb(1'b0, OFS_STANDALONE_CNT, 32'h0);
         rng(rd, 1024 / ratio[p], 3);
      end
      // period match, masked then unmasked interrupt
      wr(OFS_STANDALONE_CNT, 32'h0);
      wr(OFS_STANDALONE_PER, 32'h3);
      wr(OFS_STANDALONE_CTL, 32'h8000);
      waitc(12);
      check({31'h0, irq}, 32'h0);
      rdc(OFS_IRQ_STATUS, 32'h1);
      wr(OFS_IRQ_MASK, 32'h1);
      waitc(2);
      check({31'h0, irq}, 32'h1);
      wr(OFS_STANDALONE_CTL, 32'h0);
      apb(1'b0, OFS_STANDALONE_CNT, 32'h0);
      check({31'h0, rd <= 32'h3}, 32'h1);
      waitc(20);
      rdc(OFS_STANDALONE_CNT, rd);
      wr(OFS_IRQ_STATUS, 32'h1);
      waitc(2);
      check({31'h0, irq}, 32'h0);
      rdc(OFS_IRQ_STATUS, 32'h0);
      wr(OFS_STANDALONE_PER, 32'hffff);
      for (int i = 0; i < 3; i++) begin
         wr(exCnt[i], 32'h0);
         wr(exCtl[i], exVal[i]);
         u_pin.pulse(i / 2, 5);
         waitc(4);
         rdc(exCnt[i], 32'h5);
         wr(exCtl[i], 32'h0);
      end
      wr(OFS_STANDALONE_CNT, 32'h0);
      wr(OFS_STANDALONE_CTL, 32'h8040);
      waitc(20);
      rdc(OFS_STANDALONE_CNT, 32'h0);
      u_pin.level(0, 1'b1);
      waitc(20);
      u_pin.level(0, 1'b0);
      waitc(6);
      apb(1'b0, OFS_STANDALONE_CNT, 32'h0);
      rng(rd, 10, 3);
      rdc(OFS_IRQ_STATUS, 32'h1);
      wr(OFS_STANDALONE_CTL, 32'h0);
      wr(OFS_IRQ_STATUS, 32'h7);
      for (int h = 0; h < 2; h++) begin
         wr(OFS_STANDALONE_CNT, 32'h0);
         chipIdle <= 1'b1;
         wr(OFS_STANDALONE_CTL, 32'h8000 | (h << 13));
         waitc(20);
         wr(OFS_STANDALONE_CTL, 32'h0);
         chipIdle <= 1'b0;
         apb(1'b0, OFS_STANDALONE_CNT, 32'h0);
         check({31'h0, rd == 32'h0}, h);
      end
      // rewriting control faster than one 1:8 tick keeps the count at zero
      wr(OFS_STANDALONE_CNT, 32'h0);
      repeat (20) begin
         wr(OFS_STANDALONE_CTL, 32'h8010);
         waitc(6);
      end
      wr(OFS_STANDALONE_CTL, 32'h0);
      rdc(OFS_STANDALONE_CNT, 32'h0);
      wr(OFS_PAIR_HIGH_CTL, 32'h8030);
      wr(OFS_PAIR_LOW_CNT, 32'hfffe);
      wr(OFS_PAIR_LOW_CTL, 32'h8008);
      waitc(20);
      wr(OFS_PAIR_LOW_CTL, 32'h0008);
      rdc(OFS_PAIR_HIGH_CNT, 32'h1);
      wr(OFS_PAIR_LOW_CNT, 32'h0);
      wr(OFS_PAIR_HIGH_CNT, 32'h0);
      wr(OFS_PAIR_LOW_PER, 32'h4);
      wr(OFS_PAIR_HIGH_PER, 32'h1);
      wr(OFS_IRQ_MASK, 32'h6);
      wr(OFS_PAIR_LOW_CTL, 32'h8008);
      waitc(40);
      wr(OFS_PAIR_LOW_CTL, 32'h0008);
      rdc(OFS_IRQ_STATUS, 32'h0);
      wr(OFS_PAIR_LOW_CNT, 32'h0);
      wr(OFS_PAIR_HIGH_CNT, 32'h1);
      a0 = adcSeen;
      wr(OFS_PAIR_LOW_CTL, 32'h8008);
      waitirq();
      waitc(2);
      wr(OFS_PAIR_LOW_CTL, 32'h0);
      rdc(OFS_IRQ_STATUS, 32'h4);
      check(adcSeen - a0, 32'h1);
      // stop first: clears the high prescaler left running
      wr(OFS_PAIR_HIGH_CTL, 32'h0);
      wr(OFS_PAIR_HIGH_CNT, 32'h0);
      wr(OFS_PAIR_HIGH_PER, 32'h1);
      a0 = adcSeen;
      wr(OFS_PAIR_HIGH_CTL, 32'h8000);
      waitc(10);
      wr(OFS_PAIR_HIGH_CTL, 32'h0);
      waitc(2);
      rng(adcSeen - a0, 3, 1);
      complete_run();
   end
endmodule
